//--- bench/rxsc_bb.sv
`timescale 1ns/10ps
module rxsc_bb (
	// sample pins
	input wire logic clk,
	input wire logic [3:0] pins,
	// captured word
	output logic [3:0] word
);
	// baseband takes the pins every cycle
	always_ff @(posedge clk) begin
		word <= pins;
	end
endmodule : rxsc_bb

//--- bench/rxsc_properties.sv
`timescale 1ns/10ps
module rxsc_chk (
	// clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// configuration
	input wire logic [9:0] ref_divide_ratio,
	input wire logic [14:0] int_divide_ratio,
	input wire logic [4:0] crystal_trim_word,
	input wire logic [1:0] refclk_out_select,
	input wire logic [1:0] output_driver_select,
	input wire logic sample_en,
	// outputs
	input wire logic comp_tick,
	input wire logic [4:0] trim_cap,
	input wire logic [1:0] refclk_mode,
	input wire logic analog_bypass,
	input wire logic int_ratio_valid,
	input wire logic inphase_bit_one_out,
	input wire logic inphase_bit_zero_out,
	input wire logic quadrature_bit_one_out,
	input wire logic quadrature_bit_zero_out
);
	logic [3:0] pins;
	assign pins = {inphase_bit_one_out, inphase_bit_zero_out,
		quadrature_bit_one_out, quadrature_bit_zero_out};
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	property p_byp; output_driver_select[1] |=> analog_bypass; endproperty
	a_byp: assert property (p_byp) else $error("bypass late");
	property p_ana; analog_bypass |-> pins == 4'h0; endproperty
	a_ana: assert property (p_ana) else $error("pins in bypass");
	property p_rsv; output_driver_select != 2'h0 |=> pins == 4'h0; endproperty
	a_rsv: assert property (p_rsv) else $error("pins not low");
	property p_trm;
		$past(nrst) && $stable(crystal_trim_word)
			|-> trim_cap == crystal_trim_word;
	endproperty
	a_trm: assert property (p_trm) else $error("trim wrong");
	property p_ref;
		$past(nrst) && $stable(refclk_out_select)
			|-> refclk_mode == refclk_out_select;
	endproperty
	a_ref: assert property (p_ref) else $error("refclk mode");
	property p_val; $past(nrst) && $stable(int_divide_ratio)
		|-> int_ratio_valid == (int_divide_ratio >= 15'h0024); endproperty
	a_val: assert property (p_val) else $error("ratio valid");
	property p_tck; comp_tick && ref_divide_ratio == 10'h005
		|=> !comp_tick [*4] ##1 comp_tick; endproperty
	a_tck: assert property (p_tck) else $error("tick spacing");
	property p_hld; $changed(pins) |-> ($past(sample_en, 3) &&
		!$past(sample_en, 4)) || $past(output_driver_select) != 2'h0; endproperty
	a_hld: assert property (p_hld) else $error("pins moved");
	c_tck: cover property (comp_tick);
	c_byp: cover property (analog_bypass);
	c_smp: cover property ($changed(pins));
endmodule : rxsc_chk

//--- bench/testbench.sv
`timescale 1ns/10ps
module testbench;
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	// 2 MHz comparison from 10 MHz
	logic [9:0] ref_divide_ratio = 10'h005;
	logic [14:0] int_divide_ratio = 15'h004e;
	logic [19:0] frac_divide_ratio = 20'h0_0000;
	logic [4:0] crystal_trim_word = 5'h15;
	logic [1:0] refclk_out_select = 2'h3, output_driver_select = 2'h0;
	logic [1:0] output_format = 2'h1, refclk_mode;
	logic [2:0] bit_count = 3'h2, inphase_level = 3'h0, quad_level = 3'h0;
	logic quad_channel_enable = 1'b1, sample_en = 1'b0;
	logic comp_tick, analog_bypass, int_ratio_valid;
	logic inphase_bit_one_out, inphase_bit_zero_out;
	logic quadrature_bit_one_out, quadrature_bit_zero_out;
	logic [14:0] main_div_now;
	logic [4:0] trim_cap;
	logic [3:0] word;
	int n_mismatch = 0, total_checks = 0;
	rxsc_core uut (.ref_clk, .nrst, .ref_divide_ratio, .int_divide_ratio,
		.frac_divide_ratio, .crystal_trim_word, .refclk_out_select,
		.output_driver_select, .output_format, .bit_count,
		.quad_channel_enable, .sample_en, .inphase_level, .quad_level,
		.comp_tick, .main_div_now, .trim_cap, .refclk_mode, .analog_bypass,
		.int_ratio_valid, .inphase_bit_one_out, .inphase_bit_zero_out,
		.quadrature_bit_one_out, .quadrature_bit_zero_out);
	rxsc_bb bb (.clk(ref_clk), .word, .pins({inphase_bit_one_out,
		inphase_bit_zero_out, quadrature_bit_one_out, quadrature_bit_zero_out}));
	always #50 ref_clk = ~ref_clk;
	task automatic chk(input logic [19:0] got, input logic [19:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : cyc
	task automatic samp(input logic [2:0] i, input logic [2:0] q);
		inphase_level <= i;
		quad_level <= q;
		sample_en <= 1'b1;
		cyc(2);
		sample_en <= 1'b0;
		cyc(3);
	endtask : samp
	// level index 0..7 stands for -7..+7
	function automatic logic [2:0] code(input logic [1:0] f,
		input logic [2:0] k);
		if (f[1]) return k ^ 3'h4;
		if (f == 2'h0) return k;
		return k[2] ? k - 3'h4 : {1'b1, 2'h3 - k[1:0]};
	endfunction : code
	function automatic logic [3:0] pinx(input logic [2:0] a,
		input logic [2:0] b);
		logic q;
		q = quad_channel_enable;
		if (bit_count == 3'h0) return {1'b0, a[2], 1'b0, q & b[2]};
		if (bit_count == 3'h2 || q) return {a[2:1], q ? b[2:1] : 2'h0};
		return {a, 1'b0};
	endfunction : pinx
	task automatic t_fmt();
		logic [3:0] exp_w;
		// code 6 stands for the unknown widths, which act as three bits
		for (int b = 0; b < 8; b++) begin
			bit_count <= 3'(b / 2 * 2);
			quad_channel_enable <= b[0];
			for (int f = 0; f < 4; f++) begin
				output_format <= 2'(f);
				for (int k = 0; k < 8; k += 3) begin
					samp(3'(k), 3'(7 - k));
					exp_w = pinx(code(2'(f), 3'(k)), code(2'(f), 3'(7 - k)));
					chk(word, exp_w);
				end
			end
		end
	endtask : t_fmt
	task automatic t_drv();
		logic [3:0] exp_w;
		for (int d = 1; d < 4; d++) begin
			output_driver_select <= 2'(d);
			samp(3'h7, 3'h7);
			chk({analog_bypass, word}, {d > 1, 4'h0});
		end
		output_driver_select <= 2'h0;
		samp(3'h7, 3'h0);
		exp_w = pinx(code(output_format, 3'h7), code(output_format, 3'h0));
		chk(word, exp_w);
	endtask : t_drv
	// crystal is 10 MHz, so every output select is allowed
	task automatic t_cfg();
		for (int r = 0; r < 4; r++) begin
			refclk_out_select <= 2'(r);
			crystal_trim_word <= 5'(r * 9);
			int_divide_ratio <= 15'(r + 34);
			cyc(3);
			chk({refclk_mode, trim_cap}, {2'(r), 5'(r * 9)});
			chk(int_ratio_valid, r > 1);
		end
		int_divide_ratio <= 15'h004e;
	endtask : t_cfg
	task automatic t_tck();
		int n = 0;
		int s = 0;
		frac_divide_ratio <= 20'h8_0000;
		cyc(10);
		repeat (40) begin
			@(posedge ref_clk);
			if (comp_tick === 1'b1) begin
				n++;
				s += main_div_now;
			end
		end
		chk(n, 8);
		chk(s, 8 * 78 + 4);
	endtask : t_tck
	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : results
	initial begin
		cyc(12);
		nrst <= 1'b1;
		cyc(3);
		t_fmt();
		t_drv();
		t_cfg();
		t_tck();
		results();
	end
	initial begin
		#200_000;
		n_mismatch++;
		results();
	end
endmodule : testbench
bind rxsc_core rxsc_chk chk_i (.ref_clk, .nrst, .ref_divide_ratio,
	.int_divide_ratio, .crystal_trim_word, .refclk_out_select,
	.output_driver_select, .sample_en, .comp_tick, .trim_cap, .refclk_mode,
	.analog_bypass, .int_ratio_valid, .inphase_bit_one_out,
	.inphase_bit_zero_out, .quadrature_bit_one_out, .quadrature_bit_zero_out);

//--- logic/rxsc_core.sv
`timescale 1ns/10ps
module rxsc_core (
	// clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// synthesizer configuration
	input wire logic [rxsc_pkg::REF_RATIO_W-1:0] ref_divide_ratio,
	input wire logic [rxsc_pkg::INT_W-1:0] int_divide_ratio,
	input wire logic [rxsc_pkg::FRAC_W-1:0] frac_divide_ratio,
	input wire logic [rxsc_pkg::TRIM_W-1:0] crystal_trim_word,
	input wire logic [1:0] refclk_out_select,
	// converter configuration
	input wire logic [1:0] output_driver_select,
	input wire logic [1:0] output_format,
	input wire logic [2:0] bit_count,
	input wire logic quad_channel_enable,
	// samples from the quantizer, pin domain
	input wire logic sample_en,
	input wire logic [2:0] inphase_level,
	input wire logic [2:0] quad_level,
	// synthesizer and oscillator controls
	output logic comp_tick,
	output logic [rxsc_pkg::INT_W-1:0] main_div_now,
	output logic [rxsc_pkg::TRIM_W-1:0] trim_cap,
	output logic [1:0] refclk_mode,
	output logic analog_bypass,
	output logic int_ratio_valid,
	// sample outputs
	output logic inphase_bit_one_out,
	output logic inphase_bit_zero_out,
	output logic quadrature_bit_one_out,
	output logic quadrature_bit_zero_out
);
	////////////////////////////////////////////////////////////////////
	logic [rxsc_pkg::REF_RATIO_W-1:0] ref_cnt_reg;
	logic [rxsc_pkg::FRAC_W:0] frac_acc_reg;
	logic [rxsc_pkg::FRAC_W:0] frac_sum;
	logic [rxsc_pkg::REF_RATIO_W-1:0] ref_ratio_eff;
	logic [2:0] en_sync_reg;
	logic [2:0] i_s1_reg, i_s2_reg, q_s1_reg, q_s2_reg;
	logic [2:0] i_code, q_code;
	logic [2:0] nbits_eff;
	rxsc_fmt_if fi ();
	rxsc_fmt_if fq ();

	// width actually used; unknown codes act as three bits
	function automatic logic [2:0] eff_bits(input logic [2:0] code,
		input logic quad);
		if (code == rxsc_pkg::BITS_ONE)
			return rxsc_pkg::BITS_ONE;
		// two channels cannot share three bits
		if (code == rxsc_pkg::BITS_TWO || quad)
			return rxsc_pkg::BITS_TWO;
		return rxsc_pkg::BITS_THREE;
	endfunction : eff_bits

	// zero divisor is illegal; treat as one
	assign ref_ratio_eff = (ref_divide_ratio == '0) ?
		rxsc_pkg::REF_RATIO_MIN : ref_divide_ratio;
	assign frac_sum = frac_acc_reg + {1'b0, frac_divide_ratio};
	assign nbits_eff = eff_bits(bit_count, quad_channel_enable);

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			ref_cnt_reg <= '0;
			comp_tick <= 1'b0;
		end else if (ref_cnt_reg >= ref_ratio_eff - rxsc_pkg::REF_RATIO_MIN)
				begin
			ref_cnt_reg <= '0;
			comp_tick <= 1'b1;
		end else begin
			ref_cnt_reg <= ref_cnt_reg + rxsc_pkg::REF_RATIO_MIN;
			comp_tick <= 1'b0;
		end
	end

	// first-order accumulator: carry adds one to the ratio
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			frac_acc_reg <= '0;
			main_div_now <= rxsc_pkg::INT_MIN;
		end else if (comp_tick) begin
			frac_acc_reg <= {1'b0, frac_sum[rxsc_pkg::FRAC_W-1:0]};
			main_div_now <= int_divide_ratio +
				{{(rxsc_pkg::INT_W-1){1'b0}}, frac_sum[rxsc_pkg::FRAC_W]};
		end
	end

	// range flag; stays the host's job
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst)
			int_ratio_valid <= 1'b0;
		else
			int_ratio_valid <= int_divide_ratio >= rxsc_pkg::INT_MIN;
	end

	// trim word, clock out mode, bypass
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			trim_cap <= '0;
			refclk_mode <= rxsc_pkg::REF_X1;
			analog_bypass <= 1'b0;
		end else begin
			trim_cap <= crystal_trim_word;
			refclk_mode <= refclk_out_select;
			analog_bypass <= output_driver_select[1];
		end
	end

	////////////////////////////////////////////////////////////////////
	// pin-domain samples pass two flops; enable edge after the second
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			en_sync_reg <= '0;
			i_s1_reg <= '0;
			i_s2_reg <= '0;
			q_s1_reg <= '0;
			q_s2_reg <= '0;
		end else begin
			en_sync_reg <= {en_sync_reg[1:0], sample_en};
			i_s1_reg <= inphase_level;
			i_s2_reg <= i_s1_reg;
			q_s1_reg <= quad_level;
			q_s2_reg <= q_s1_reg;
		end
	end

	assign fi.level = i_s2_reg;
	assign fi.format = output_format;
	assign fi.nbits = nbits_eff;
	assign fq.level = q_s2_reg;
	assign fq.format = output_format;
	assign fq.nbits = nbits_eff;
	assign i_code = fi.code;
	assign q_code = fq.code;
	rxsc_fmt u_fmt_i (.f(fi.conv));
	rxsc_fmt u_fmt_q (.f(fq.conv));

	// one sample per enable rising edge
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			inphase_bit_one_out <= 1'b0;
			inphase_bit_zero_out <= 1'b0;
			quadrature_bit_one_out <= 1'b0;
			quadrature_bit_zero_out <= 1'b0;
		end else if (output_driver_select != rxsc_pkg::DRV_DIGITAL) begin
			inphase_bit_one_out <= 1'b0;
			inphase_bit_zero_out <= 1'b0;
			quadrature_bit_one_out <= 1'b0;
			quadrature_bit_zero_out <= 1'b0;
		end else if (en_sync_reg[1] && !en_sync_reg[2]) begin
			if (nbits_eff == rxsc_pkg::BITS_THREE) begin
				inphase_bit_one_out <= i_code[2];
				inphase_bit_zero_out <= i_code[1];
				quadrature_bit_one_out <= i_code[0];
				quadrature_bit_zero_out <= 1'b0;
			end else if (nbits_eff == rxsc_pkg::BITS_ONE) begin
				inphase_bit_one_out <= 1'b0;
				inphase_bit_zero_out <= i_code[0];
				quadrature_bit_one_out <= 1'b0;
				quadrature_bit_zero_out <= quad_channel_enable & q_code[0];
			end else begin
				// two bits: msb on bit one
				// Q only when enabled; 3-bit with Q falls to 2
				inphase_bit_one_out <= i_code[1];
				inphase_bit_zero_out <= i_code[0];
				quadrature_bit_one_out <= quad_channel_enable & q_code[1];
				quadrature_bit_zero_out <= quad_channel_enable & q_code[0];
			end
		end
	end
endmodule : rxsc_core

//--- logic/rxsc_fmt.sv
`timescale 1ns/10ps
// maps odd-level quantizer index (0 = -7 .. 7 = +7) to output code
module rxsc_fmt (
	rxsc_fmt_if.conv f
);
	logic neg;
	logic [2:0] mag;
	always_comb begin
		neg = ~f.level[2];
		mag = neg ? ~f.level : f.level;
		f.code = 3'h0;
		unique case (f.nbits)
			rxsc_pkg::BITS_ONE: begin
				f.code = {2'h0, f.level[2]};
				if (f.format != rxsc_pkg::FMT_UNSIGNED)
					f.code = {2'h0, neg};
			end
			rxsc_pkg::BITS_TWO: begin
				if (f.format == rxsc_pkg::FMT_UNSIGNED)
					f.code = {1'b0, f.level[2:1]};
				else if (f.format == rxsc_pkg::FMT_SIGNMAG)
					f.code = {1'b0, neg, mag[1]};
				else
					f.code = {1'b0, f.level[2:1] ^ 2'h2};
			end
			default: begin
				if (f.format == rxsc_pkg::FMT_UNSIGNED)
					f.code = f.level;
				else if (f.format == rxsc_pkg::FMT_SIGNMAG)
					f.code = {neg, mag[1:0]};
				else
					f.code = f.level ^ 3'h4;
			end
		endcase
	end
endmodule : rxsc_fmt

//--- logic/rxsc_fmt_if.sv
`timescale 1ns/10ps
interface rxsc_fmt_if;
	logic [2:0] level;
	logic [1:0] format;
	logic [2:0] nbits;
	logic [2:0] code;
	modport ctrl (output level, output format, output nbits, input code);
	modport conv (input level, input format, input nbits, output code);
endinterface : rxsc_fmt_if

//--- logic/rxsc_pkg.sv
package rxsc_pkg;
	localparam int REF_RATIO_W = 10;
	localparam int INT_W = 15;
	localparam int FRAC_W = 20;
	localparam int TRIM_W = 5;
	localparam int SAMP_W = 3;
	localparam logic [REF_RATIO_W-1:0] REF_RATIO_MIN = 10'h001;
	localparam logic [INT_W-1:0] INT_MIN = 15'h0024;
	localparam logic [FRAC_W:0] FRAC_ONE = 21'h10_0000;
	localparam logic [1:0] DRV_DIGITAL = 2'h0;
	localparam logic [1:0] DRV_RESERVED = 2'h1;
	localparam logic [1:0] FMT_UNSIGNED = 2'h0;
	localparam logic [1:0] FMT_SIGNMAG = 2'h1;
	localparam logic [2:0] BITS_ONE = 3'h0;
	localparam logic [2:0] BITS_TWO = 3'h2;
	localparam logic [2:0] BITS_THREE = 3'h4;
	localparam logic [1:0] REF_X2 = 2'h0;
	localparam logic [1:0] REF_DIV4 = 2'h1;
	localparam logic [1:0] REF_DIV2 = 2'h2;
	localparam logic [1:0] REF_X1 = 2'h3;
	// signed sample level where the two-bit magnitude threshold sits
	localparam logic signed [SAMP_W:0] MAG_THRESH = 4'sh1;
endpackage : rxsc_pkg
